/* File: hw/acf_pkg.sv */
// Constants for the anti-collision filter command block
package acf_pkg;
    // Host command codes and lengths
    localparam logic [7:0] CMD_FILTER   = 8'h0d;
    localparam logic [7:0] CMD_ECHO     = 8'h55;
    localparam logic [7:0] LEN_DEACT    = 8'h00;
    localparam logic [7:0] LEN_FORCE    = 8'h01;
    localparam logic [7:0] LEN_QUERY    = 8'h02;
    localparam logic [7:0] LEN_ACT1     = 8'h07;
    localparam logic [7:0] LEN_ACT2     = 8'h0b;
    localparam logic [7:0] LEN_ACT3     = 8'h0f;
    // Reply codes
    localparam logic [7:0] RES_OK       = 8'h00;
    localparam logic [7:0] RES_BAD_LEN  = 8'h82;
    localparam logic [7:0] RES_LEN_NONE = 8'h00;
    localparam logic [7:0] RES_LEN_ONE  = 8'h01;
    // Emulation state encoding
    localparam logic [7:0] ST_IDLE      = 8'h00;
    localparam logic [7:0] ST_READYA    = 8'h01;
    localparam logic [7:0] ST_ACTIVE    = 8'h04;
    localparam logic [7:0] ST_HALT      = 8'h80;
    localparam logic [7:0] ST_READYA_S  = 8'h81;
    localparam int         ST_STAR_BIT  = 7;
    localparam logic [7:0] ST_RESET     = ST_IDLE;
    // Reader frame codes
    localparam logic [7:0] RD_SENS      = 8'h26;
    localparam logic [7:0] RD_ALL       = 8'h52;
    localparam logic [7:0] RD_SDD1      = 8'h93;
    localparam logic [7:0] RD_SDD2      = 8'h95;
    localparam logic [7:0] RD_SDD3      = 8'h97;
    localparam logic [7:0] RD_NVB_SDD   = 8'h20;
    localparam logic [7:0] RD_NVB_SEL   = 8'h70;
    localparam logic [7:0] SAK_CASCADE  = 8'h04;
    // Answer layout inside the filter configuration
    localparam int         CFG_ATQA     = 0;
    localparam int         CFG_SAK      = 2;
    localparam int         CFG_UID      = 3;
    localparam int         UID_PART     = 4;
    localparam logic [2:0] TX_ATQA_N    = 3'h2;
    localparam logic [2:0] TX_SDD_N     = 3'h5;
    localparam logic [2:0] TX_SEL_N     = 3'h1;
    typedef enum logic [1:0] {TX_ATQA, TX_SDD, TX_SEL} acf_tx_t;
endpackage : acf_pkg

/* File: hw/acf_cmd.sv */
// Anti-collision filter command, echo and reader frame routing
`timescale 1ns/100ps
module acf_cmd #(
    parameter int CFG_BYTES = 15
) (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Host command bytes and reply
    input  wire logic       i_cmd_valid,
    input  wire logic [7:0] i_cmd_byte,
    output logic            o_rsp_valid,
    output logic [7:0]      o_rsp_byte,
    output logic            o_rsp_last,
    // Listening mode
    input  wire logic       i_listen,
    output logic            o_listening,
    // Reader frames in
    input  wire logic       i_rdr_valid,
    input  wire logic [7:0] i_rdr_byte,
    input  wire logic       i_rdr_first,
    input  wire logic       i_rdr_last,
    input  wire logic       i_rdr_short,
    // Receive buffer write side
    output logic            o_buf_valid,
    output logic [7:0]      o_buf_byte,
    output logic            o_buf_last,
    // Answer to reader
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_byte,
    output logic            o_tx_last,
    // Status
    output logic            o_filter_on,
    output logic [7:0]      o_emul_state
);
    if (CFG_BYTES != 15) begin : g_chk
        $error("acf_cmd: CFG_BYTES must be 15");
    end

    typedef enum logic [1:0] {H_IDLE, H_LEN, H_PAY} acf_hst_t;

    function automatic logic [1:0] sdd_level(input logic [7:0] code);
        sdd_level = (code == acf_pkg::RD_SDD1) ? 2'd0 : (code == acf_pkg::RD_SDD2) ? 2'd1 : 2'd2;
    endfunction : sdd_level

    function automatic logic is_sdd(input logic [7:0] code);
        is_sdd = code == acf_pkg::RD_SDD1 || code == acf_pkg::RD_SDD2 || code == acf_pkg::RD_SDD3;
    endfunction : is_sdd

    acf_hst_t        hst_r, hst_nxt;
    acf_pkg::acf_tx_t tx_kind_r, tx_kind_nxt;
    logic [7:0]      cfg_r [CFG_BYTES], cfg_nxt [CFG_BYTES];
    logic [7:0]      rb_r [3], rb_nxt [3];
    logic [7:0]      len_r, len_nxt, st_r, st_nxt, hold_r, hold_nxt, aux_r, aux_nxt;
    logic [3:0]      pay_r, pay_nxt;
    logic [1:0]      rcnt_r, rcnt_nxt, ridx_r, ridx_nxt, lvls_r, lvls_nxt, lvl_r, lvl_nxt;
    logic [2:0]      tcnt_r, tcnt_nxt, tidx_r, tidx_nxt;
    logic            filt_r, filt_nxt, lis_r, lis_nxt, flush_r, flush_nxt, sec_r, sec_nxt;
    logic            drop_r, drop_nxt;
    logic            rv_nxt, rl_nxt, bv_nxt, bl_nxt, tv_nxt, tl_nxt;
    logic [7:0]      rbyte_nxt, bbyte_nxt, tbyte_nxt;
    logic [1:0]      l;
    logic [7:0]      base;
    logic [7:0]      bcc;

    always_comb begin
        hst_nxt = hst_r; tx_kind_nxt = tx_kind_r; cfg_nxt = cfg_r; rb_nxt = rb_r;
        len_nxt = len_r; st_nxt = st_r; hold_nxt = hold_r; aux_nxt = aux_r; pay_nxt = pay_r;
        rcnt_nxt = rcnt_r; ridx_nxt = ridx_r; lvls_nxt = lvls_r; lvl_nxt = lvl_r;
        tcnt_nxt = tcnt_r; tidx_nxt = tidx_r; filt_nxt = filt_r; lis_nxt = lis_r;
        flush_nxt = 1'b0; sec_nxt = sec_r; drop_nxt = drop_r;
        rv_nxt = 1'b0; rl_nxt = 1'b0; rbyte_nxt = o_rsp_byte;
        bv_nxt = 1'b0; bl_nxt = 1'b0; bbyte_nxt = o_buf_byte;
        tv_nxt = 1'b0; tl_nxt = 1'b0; tbyte_nxt = o_tx_byte;
        l = sdd_level(hold_r);
        base = {1'b0, st_r[acf_pkg::ST_STAR_BIT - 1:0]};
        bcc = 8'h00;
        for (int k = 0; k < acf_pkg::UID_PART; k++) begin
            bcc = bcc ^ cfg_r[acf_pkg::CFG_UID + acf_pkg::UID_PART * int'(l) + k];
        end
        // Host side: replies stream out before the next command is parsed
        if (rcnt_r != 2'd0) begin
            rv_nxt = 1'b1;
            rbyte_nxt = rb_r[ridx_r];
            rl_nxt = rcnt_r == 2'd1;
            ridx_nxt = ridx_r + 2'd1;
            rcnt_nxt = rcnt_r - 2'd1;
        end else if (i_cmd_valid) begin
            ridx_nxt = 2'd0;
            case (hst_r)
                H_IDLE: begin
                    if (i_cmd_byte == acf_pkg::CMD_ECHO) begin
                        rb_nxt[0] = acf_pkg::CMD_ECHO;
                        rcnt_nxt = 2'd1;
                        lis_nxt = 1'b0;
                    end else if (i_cmd_byte == acf_pkg::CMD_FILTER) begin
                        hst_nxt = H_LEN;
                    end
                end
                H_LEN: begin
                    len_nxt = i_cmd_byte;
                    pay_nxt = 4'd0;
                    hst_nxt = H_PAY;
                    if (i_cmd_byte == acf_pkg::LEN_DEACT) begin
                        filt_nxt = 1'b0;
                        rb_nxt = '{acf_pkg::RES_OK, acf_pkg::RES_LEN_ONE, st_r};
                        rcnt_nxt = 2'd3;
                        hst_nxt = H_IDLE;
                    end else if (i_cmd_byte > acf_pkg::LEN_QUERY && i_cmd_byte != acf_pkg::LEN_ACT1 &&
                                 i_cmd_byte != acf_pkg::LEN_ACT2 && i_cmd_byte != acf_pkg::LEN_ACT3) begin
                        rb_nxt[0] = acf_pkg::RES_BAD_LEN;
                        rb_nxt[1] = acf_pkg::RES_LEN_NONE;
                        rcnt_nxt = 2'd2;
                        hst_nxt = H_IDLE;
                    end
                end
                H_PAY: begin
                    if (len_r == acf_pkg::LEN_FORCE) begin
                        st_nxt = i_cmd_byte;
                    end else if (len_r > acf_pkg::LEN_QUERY) begin
                        cfg_nxt[pay_r] = i_cmd_byte;
                    end
                    pay_nxt = pay_r + 4'd1;
                    if ({4'h0, pay_r} == len_r - 8'd1) begin
                        hst_nxt = H_IDLE;
                        rb_nxt[0] = acf_pkg::RES_OK;
                        if (len_r == acf_pkg::LEN_QUERY) begin
                            rb_nxt[1] = acf_pkg::RES_LEN_ONE;
                            rb_nxt[2] = st_r;
                            rcnt_nxt = 2'd3;
                        end else begin
                            rb_nxt[1] = acf_pkg::RES_LEN_NONE;
                            rcnt_nxt = 2'd2;
                            if (len_r > acf_pkg::LEN_QUERY) begin
                                filt_nxt = 1'b1;
                                lvls_nxt = 2'((len_r - 8'd3) >> 2);
                            end
                        end
                    end
                end
                default: hst_nxt = H_IDLE;
            endcase
        end
        if (i_listen) begin
            lis_nxt = 1'b1;
        end
        // Reader answers
        if (tcnt_r != 3'd0) begin
            tv_nxt = 1'b1;
            tl_nxt = tcnt_r == 3'd1;
            case (tx_kind_r)
                acf_pkg::TX_ATQA: tbyte_nxt = cfg_r[acf_pkg::CFG_ATQA + int'(tidx_r)];
                acf_pkg::TX_SDD: tbyte_nxt = (tidx_r == 3'd4) ? aux_r :
                    cfg_r[acf_pkg::CFG_UID + acf_pkg::UID_PART * int'(lvl_r) + int'(tidx_r)];
                default: tbyte_nxt = aux_r;
            endcase
            tidx_nxt = tidx_r + 3'd1;
            tcnt_nxt = tcnt_r - 3'd1;
        end
        // Frame flush one cycle after the last byte
        if (flush_r) begin
            bv_nxt = 1'b1;
            bbyte_nxt = hold_r;
            bl_nxt = 1'b1;
        end
        if (i_rdr_valid) begin
            hold_nxt = i_rdr_byte;
            tidx_nxt = (tcnt_r == 3'd0) ? 3'd0 : tidx_nxt;
            if (i_rdr_first) begin
                sec_nxt = 1'b1;
                drop_nxt = 1'b0;
                if (i_rdr_last && filt_r && i_rdr_short && tcnt_r == 3'd0 &&
                    (i_rdr_byte == acf_pkg::RD_SENS || i_rdr_byte == acf_pkg::RD_ALL)) begin
                    if (st_r == acf_pkg::ST_IDLE) begin
                        st_nxt = acf_pkg::ST_READYA;
                        tx_kind_nxt = acf_pkg::TX_ATQA;
                        tcnt_nxt = acf_pkg::TX_ATQA_N;
                    end else if (st_r == acf_pkg::ST_HALT && i_rdr_byte == acf_pkg::RD_ALL) begin
                        st_nxt = acf_pkg::ST_READYA_S;
                        tx_kind_nxt = acf_pkg::TX_ATQA;
                        tcnt_nxt = acf_pkg::TX_ATQA_N;
                    end
                end else begin
                    flush_nxt = i_rdr_last;
                end
            end else if (!drop_r) begin
                sec_nxt = 1'b0;
                if (sec_r && filt_r && tcnt_r == 3'd0 && is_sdd(hold_r) &&
                    (i_rdr_byte == acf_pkg::RD_NVB_SDD || i_rdr_byte == acf_pkg::RD_NVB_SEL)) begin
                    drop_nxt = 1'b1;
                    lvl_nxt = l;
                    if (l < lvls_r && base == acf_pkg::ST_READYA + {6'h0, l}) begin
                        if (i_rdr_byte == acf_pkg::RD_NVB_SDD) begin
                            aux_nxt = bcc;
                            tx_kind_nxt = acf_pkg::TX_SDD;
                            tcnt_nxt = acf_pkg::TX_SDD_N;
                        end else begin
                            tx_kind_nxt = acf_pkg::TX_SEL;
                            tcnt_nxt = acf_pkg::TX_SEL_N;
                            if (l == lvls_r - 2'd1) begin
                                st_nxt = acf_pkg::ST_ACTIVE;
                                aux_nxt = cfg_r[acf_pkg::CFG_SAK] & ~acf_pkg::SAK_CASCADE;
                            end else begin
                                st_nxt = st_r + 8'd1;
                                aux_nxt = cfg_r[acf_pkg::CFG_SAK] | acf_pkg::SAK_CASCADE;
                            end
                        end
                    end
                end else begin
                    bv_nxt = 1'b1;
                    bbyte_nxt = hold_r;
                    flush_nxt = i_rdr_last;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            hst_r <= H_IDLE; tx_kind_r <= acf_pkg::TX_ATQA;
            cfg_r <= '{default: 8'h00}; rb_r <= '{default: 8'h00};
            len_r <= 8'h00; st_r <= acf_pkg::ST_RESET; hold_r <= 8'h00; aux_r <= 8'h00; pay_r <= 4'h0;
            rcnt_r <= 2'h0; ridx_r <= 2'h0; lvls_r <= 2'h0; lvl_r <= 2'h0; tcnt_r <= 3'h0; tidx_r <= 3'h0;
            filt_r <= 1'b0; lis_r <= 1'b0; flush_r <= 1'b0; sec_r <= 1'b0; drop_r <= 1'b0;
            o_rsp_valid <= 1'b0; o_rsp_byte <= 8'h00; o_rsp_last <= 1'b0;
            o_buf_valid <= 1'b0; o_buf_byte <= 8'h00; o_buf_last <= 1'b0;
            o_tx_valid <= 1'b0; o_tx_byte <= 8'h00; o_tx_last <= 1'b0;
        end else begin
            hst_r <= hst_nxt; tx_kind_r <= tx_kind_nxt; cfg_r <= cfg_nxt; rb_r <= rb_nxt;
            len_r <= len_nxt; st_r <= st_nxt; hold_r <= hold_nxt; aux_r <= aux_nxt; pay_r <= pay_nxt;
            rcnt_r <= rcnt_nxt; ridx_r <= ridx_nxt; lvls_r <= lvls_nxt; lvl_r <= lvl_nxt;
            tcnt_r <= tcnt_nxt; tidx_r <= tidx_nxt;
            filt_r <= filt_nxt; lis_r <= lis_nxt; flush_r <= flush_nxt; sec_r <= sec_nxt; drop_r <= drop_nxt;
            o_rsp_valid <= rv_nxt; o_rsp_byte <= rbyte_nxt; o_rsp_last <= rl_nxt;
            o_buf_valid <= bv_nxt; o_buf_byte <= bbyte_nxt; o_buf_last <= bl_nxt;
            o_tx_valid <= tv_nxt; o_tx_byte <= tbyte_nxt; o_tx_last <= tl_nxt;
        end
    end

    assign o_listening  = lis_r;
    assign o_filter_on  = filt_r;
    assign o_emul_state = st_r;

    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic idle_cmd;
    assign idle_cmd = i_cmd_valid && rcnt_r == 2'd0;
    sequence s_ok_none;
        o_rsp_valid && o_rsp_byte == 8'h00 ##1 o_rsp_valid && o_rsp_byte == 8'h00 && o_rsp_last;
    endsequence
    a_echo_reply: assert property (idle_cmd && hst_r == H_IDLE && i_cmd_byte == 8'h55 |-> ##2
        o_rsp_valid && o_rsp_byte == 8'h55 && o_rsp_last) else $error("echo reply wrong");
    a_echo_exit: assert property (idle_cmd && hst_r == H_IDLE && i_cmd_byte == 8'h55 && !i_listen
        |=> !o_listening) else $error("echo did not end listening");
    a_force_state: assert property (idle_cmd && hst_r == H_PAY && len_r == 8'h01 |=>
        o_emul_state == $past(i_cmd_byte) ##1 s_ok_none) else $error("state force wrong");
    a_query_state: assert property (idle_cmd && hst_r == H_PAY && len_r == 8'h02 && pay_r == 4'd1 |->
        ##2 o_rsp_byte == 8'h00 ##1 o_rsp_byte == 8'h01 && o_filter_on == $past(o_filter_on, 3)
        ##1 o_rsp_last && o_rsp_byte == o_emul_state) else $error("state query wrong");
    a_deact_filter: assert property (idle_cmd && hst_r == H_LEN && i_cmd_byte == 8'h00 |=>
        !o_filter_on ##1 o_rsp_byte == 8'h00 ##1 o_rsp_byte == 8'h01) else $error("deactivate wrong");
    a_bad_length: assert property (idle_cmd && hst_r == H_LEN && i_cmd_byte == 8'h03 |-> ##2
        o_rsp_valid && o_rsp_byte == 8'h82 ##1 o_rsp_byte == 8'h00 && o_rsp_last) else $error("no error reply");
    a_pass_frame: assert property (i_rdr_valid && i_rdr_first && i_rdr_last && !o_filter_on |-> ##2
        o_buf_valid && o_buf_last && o_buf_byte == $past(i_rdr_byte, 2)) else $error("frame not buffered");
    a_sens_answer: assert property (i_rdr_valid && i_rdr_first && i_rdr_last && i_rdr_short &&
        o_filter_on && i_rdr_byte == 8'h26 && o_emul_state == 8'h00 && tcnt_r == 3'd0 |=> o_emul_state == 8'h01
        ##1 o_tx_valid && !o_tx_last ##1 o_tx_last) else $error("sense request not answered");
    a_listen_kept: assert property (tcnt_r != 3'd0 && !i_cmd_valid && !i_listen |=>
        o_listening == $past(o_listening)) else $error("listening changed while answering");
endmodule : acf_cmd

/* File: verification/acf_host_model.sv */
// Host controller model driving command bytes and collecting replies
`timescale 1ns/100ps
module acf_host_model (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Command bytes out
    output logic            o_cmd_valid,
    output logic [7:0]      o_cmd_byte,
    // Reply bytes in
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_byte,
    input  wire logic       i_rsp_last
);
    logic [7:0] rsp_q[$];
    int         last_cnt;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_byte  = 8'h00;
        last_cnt    = 0;
    end

    always @(posedge i_clock) begin
        if (!i_rst && i_rsp_valid) begin
            rsp_q.push_back(i_rsp_byte);
            if (i_rsp_last)
                last_cnt++;
        end
    end

    // One whole frame, then no new command before the reply ends
    task automatic transact(input logic [7:0] cmd[$], output logic [7:0] rsp[$], output bit ok);
        int start;
        int n;
        start = last_cnt;
        rsp_q.delete();
        foreach (cmd[i]) begin
            @(negedge i_clock);
            o_cmd_valid = 1'b1;
            o_cmd_byte  = cmd[i];
        end
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        // Idle bus shows the inverse so stale data never looks valid
        o_cmd_byte  = ~o_cmd_byte;
        for (n = 0; n < 40 && last_cnt == start; n++)
            @(negedge i_clock);
        ok  = (last_cnt != start);
        rsp = rsp_q;
    endtask : transact
endmodule : acf_host_model

/* File: verification/tb_acf_cmd.sv */
// Self-checking bench for the anti-collision filter command block
`timescale 1ns/100ps
module tb_acf_cmd;
    logic       clk;
    logic       rst;
    logic       cmd_valid;
    logic [7:0] cmd_byte;
    logic       rsp_valid;
    logic [7:0] rsp_byte;
    logic       rsp_last;
    logic       listen;
    logic       listening;
    logic       rdr_valid;
    logic [7:0] rdr_byte;
    logic       rdr_first;
    logic       rdr_last;
    logic       rdr_short;
    logic       buf_valid;
    logic [7:0] buf_byte;
    logic       buf_last;
    logic       tx_valid;
    logic [7:0] tx_byte;
    logic       tx_last;
    logic       filter_on;
    logic [7:0] emul_state;
    logic [7:0] buf_q[$];
    logic [7:0] tx_q[$];
    logic [7:0] cfg[15];
    logic [7:0] uid[$];
    logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h81, 8'h82, 8'h83};
    logic [7:0] cq[$];
    logic [7:0] len;
    logic [15:0] lfsr_s = 16'h123d;
    int         err_count = 0;
    int         cmp_count = 0;
    int         buf_end = 0;
    int         tx_end = 0;

    acf_cmd #(.CFG_BYTES(15)) DUT (.i_clock(clk), .i_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte),
        .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte), .o_rsp_last(rsp_last), .i_listen(listen),
        .o_listening(listening), .i_rdr_valid(rdr_valid), .i_rdr_byte(rdr_byte), .i_rdr_first(rdr_first),
        .i_rdr_last(rdr_last), .i_rdr_short(rdr_short), .o_buf_valid(buf_valid), .o_buf_byte(buf_byte),
        .o_buf_last(buf_last), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .o_tx_last(tx_last),
        .o_filter_on(filter_on), .o_emul_state(emul_state));
    acf_host_model HOST (.i_clock(clk), .i_rst(rst), .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte),
        .i_rsp_valid(rsp_valid), .i_rsp_byte(rsp_byte), .i_rsp_last(rsp_last));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Only the first last marker counts, so an early one shows as a short frame
    always @(posedge clk) begin
        if (buf_valid === 1'b1) begin
            buf_q.push_back(buf_byte);
            if (buf_last === 1'b1 && buf_end == 0)
                buf_end = buf_q.size();
        end
        if (tx_valid === 1'b1) begin
            tx_q.push_back(tx_byte);
            if (tx_last === 1'b1 && tx_end == 0)
                tx_end = tx_q.size();
        end
    end

    function automatic logic [7:0] rnd8();
        lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
        return lfsr_s[7:0];
    endfunction : rnd8

    function automatic logic [7:0] bcc(input logic [7:0] u[$]);
        return u[0] ^ u[1] ^ u[2] ^ u[3];
    endfunction : bcc

    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$]);
        cmp8(8'(g.size()), 8'(e.size()));
        foreach (e[i])
            if (i < g.size())
                cmp8(g[i], e[i]);
    endtask : cmp_q

    task automatic cmp_frame(input logic [7:0] g[$], input int g_end, input logic [7:0] e[$]);
        cmp_q(g, e);
        cmp8(8'(g_end), 8'(e.size()));
    endtask : cmp_frame

    task automatic host_cmd(input logic [7:0] c[$], input logic [7:0] e[$]);
        logic [7:0] r[$];
        bit         ok;
        HOST.transact(c, r, ok);
        if (!ok) begin
            err_count++;
            $display("Error at %0t: no reply", $time);
        end
        cmp_q(r, e);
    endtask : host_cmd

    task automatic rdr_frame(input logic [7:0] f[$], input logic sh);
        buf_q.delete();
        tx_q.delete();
        buf_end = 0;
        tx_end = 0;
        foreach (f[i]) begin
            @(negedge clk);
            {rdr_valid, rdr_first, rdr_last, rdr_short} = {1'b1, i == 0, i == f.size() - 1, sh};
            rdr_byte = f[i];
        end
        @(negedge clk);
        {rdr_valid, rdr_first, rdr_last, rdr_short} = 4'h0;
        rdr_byte = ~rdr_byte;
        repeat (8) @(negedge clk);
    endtask : rdr_frame

    task automatic pulse_listen();
        @(negedge clk);
        listen = 1'b1;
        @(negedge clk);
        listen = 1'b0;
        @(negedge clk);
    endtask : pulse_listen

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        {rst, listen, rdr_valid, rdr_first, rdr_last, rdr_short, rdr_byte} = {6'h20, 8'h00};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp_q('{emul_state, {7'h00, filter_on}, {7'h00, listening}}, '{8'h00, 8'h00, 8'h00});
        host_cmd('{8'h55}, '{8'h55});
        pulse_listen();
        cmp8({7'h00, listening}, 8'h01);
        host_cmd('{8'h55}, '{8'h55});
        cmp8({7'h00, listening}, 8'h00);
        foreach (codes[i]) begin
            host_cmd('{8'h0d, 8'h01, codes[i]}, '{8'h00, 8'h00});
            cmp8(emul_state, codes[i]);
            host_cmd('{8'h0d, 8'h02, 8'h00, 8'h00}, '{8'h00, 8'h01, codes[i]});
            cmp8({7'h00, filter_on}, 8'h00);
        end
        for (int j = 0; j < 6; j++) begin
            len = (j == 0) ? 8'h03 : (j == 1) ? 8'hff : rnd8();
            if (len < 8'h03 || len == 8'h07 || len == 8'h0b || len == 8'h0f)
                len = 8'h10;
            host_cmd('{8'h0d, len}, '{8'h82, 8'h00});
        end
        cq = '{rnd8(), rnd8(), rnd8(), rnd8()};
        rdr_frame(cq, 1'b0);
        cmp_frame(buf_q, buf_end, cq);
        rdr_frame('{8'h26}, 1'b1);
        cmp_frame(buf_q, buf_end, '{8'h26});
        // Three cascade levels so every SDD and SEL code is reached
        cfg = '{8'h04, 8'h00, 8'h20, rnd8(), rnd8(), rnd8(), rnd8(), rnd8(), rnd8(), rnd8(), rnd8(),
                rnd8(), rnd8(), rnd8(), rnd8()};
        cq = '{8'h0d, 8'h0f};
        foreach (cfg[i])
            cq.push_back(cfg[i]);
        host_cmd(cq, '{8'h00, 8'h00});
        cmp8({7'h00, filter_on}, 8'h01);
        host_cmd('{8'h0d, 8'h01, 8'h00}, '{8'h00, 8'h00});
        host_cmd('{8'h0d, 8'h02, 8'h00, 8'h00}, '{8'h00, 8'h01, 8'h00});
        cmp8({7'h00, filter_on}, 8'h01);
        pulse_listen();
        rdr_frame('{8'h26}, 1'b1);
        cmp_frame(tx_q, tx_end, '{cfg[0], cfg[1]});
        cmp_q('{emul_state, 8'(buf_q.size())}, '{8'h01, 8'h00});
        for (int k = 0; k < 3; k++) begin
            uid = '{cfg[3 + 4 * k], cfg[4 + 4 * k], cfg[5 + 4 * k], cfg[6 + 4 * k]};
            rdr_frame('{8'h93 + 8'(2 * k), 8'h20}, 1'b0);
            cmp_frame(tx_q, tx_end, '{uid[0], uid[1], uid[2], uid[3], bcc(uid)});
            cmp8(emul_state, 8'h01 + 8'(k));
            rdr_frame('{8'h93 + 8'(2 * k), 8'h70, uid[0], uid[1], uid[2], uid[3], bcc(uid)}, 1'b0);
            cmp_frame(tx_q, tx_end, '{(k < 2) ? 8'h24 : 8'h20});
            cmp8(emul_state, (k < 2) ? 8'h02 + 8'(k) : 8'h04);
        end
        cmp8({7'h00, listening}, 8'h01);
        rdr_frame('{8'he0, 8'h50}, 1'b0);
        cmp_frame(buf_q, buf_end, '{8'he0, 8'h50});
        cmp8(8'(tx_q.size()), 8'h00);
        host_cmd('{8'h0d, 8'h01, 8'h80}, '{8'h00, 8'h00});
        rdr_frame('{8'h52}, 1'b1);
        cmp_frame(tx_q, tx_end, '{cfg[0], cfg[1]});
        cmp8(emul_state, 8'h81);
        host_cmd('{8'h55}, '{8'h55});
        cmp8({7'h00, listening}, 8'h00);
        host_cmd('{8'h0d, 8'h00}, '{8'h00, 8'h01, 8'h81});
        cmp8({7'h00, filter_on}, 8'h00);
        // Single level, stored answer has the cascade bit that the final level must clear
        cq = '{8'h0d, 8'h07, 8'h44, 8'h00, 8'h24, rnd8(), rnd8(), rnd8(), rnd8()};
        host_cmd(cq, '{8'h00, 8'h00});
        uid = cq[5:8];
        host_cmd('{8'h0d, 8'h01, 8'h00}, '{8'h00, 8'h00});
        rdr_frame('{8'h26}, 1'b1);
        cmp_frame(tx_q, tx_end, '{8'h44, 8'h00});
        rdr_frame('{8'h95, 8'h20}, 1'b0);
        cmp8(8'(tx_q.size() + buf_q.size()), 8'h00);
        rdr_frame('{8'h93, 8'h20}, 1'b0);
        cmp_frame(tx_q, tx_end, '{uid[0], uid[1], uid[2], uid[3], bcc(uid)});
        rdr_frame('{8'h93, 8'h70, uid[0], uid[1], uid[2], uid[3], bcc(uid)}, 1'b0);
        cmp_frame(tx_q, tx_end, '{8'h20});
        cmp8(emul_state, 8'h04);
        finish_test();
    end
endmodule : tb_acf_cmd
